// [core/mcfe_frame_encoder.v]
// Manchester current frame encoder with AXI4-Lite register access.
// Assumes one 200 MHz clock, synchronous active-low reset from power-on
// reset, and a supply_ok level synchronous to the clock.
//
// Overview of operation
// - every bit carries a mid-bit transition for receiver synchronisation.
// - a one bit gives a falling current edge at mid-bit.
// - a zero bit gives a rising current edge at mid-bit.
// - each frame is exactly thirteen bits.
// - every frame starts with two zero start bits.
// - a two-bit frame label follows the start bits.
// - four frames form a package; the rate counts packages.
// - a parity bit ends every frame.
// - parity is odd for manufacturing packages, even for measurement ones.
// - package rate selectable between 1 kHz and 2 kHz.
// - one-way link; the device alone times all transmissions.
// - bits are sent by switching between low and high current.
// - between packages the output stays at low current.
// - the encoder makes all message timing and drives the output.
// - a three-bit protocol selector enables only the Manchester modes.
// - an eight-bit count sets startup manufacturing packages.
// - a package information bit is inserted into measurement packages and the first manufacturing package.
// - labels are 11, 10, 01, 00 for frames one to four.
// - manufacturing parity makes the frame's count of ones odd.
// - manufacturing packages only after reset; supply dips resume measurement.
`timescale 1ns/1ps
`include "mcfe_map.vh"

module mcfe_frame_encoder #(
  parameter PKG_CYCLES_1K = (`MCFE_PKG_TIME_1K_US * `MCFE_PS_PER_US) / `MCFE_CLK_PERIOD_PS,
  parameter PKG_CYCLES_2K = (`MCFE_PKG_TIME_2K_US * `MCFE_PS_PER_US) / `MCFE_CLK_PERIOD_PS,
  parameter HALF_BIT_CYCLES = (`MCFE_HALF_BIT_NS * `MCFE_PS_PER_NS) / `MCFE_CLK_PERIOD_PS,
  parameter GAP_CYCLES = (`MCFE_FRAME_GAP_NS * `MCFE_PS_PER_NS) / `MCFE_CLK_PERIOD_PS
)
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Supply monitor, low during a dip above the reset threshold
  input wire supply_ok,
  // Current modulation output
  output wire tx_current_high,
  output reg tx_active
);

  localparam ST_IDLE = 3'h1;
  localparam ST_BIT = 3'h2;
  localparam ST_GAP = 3'h4;
  localparam [`MCFE_TMR_W-1:0] PKG_LAST_1K = PKG_CYCLES_1K[`MCFE_TMR_W-1:0] - 1'b1;
  localparam [`MCFE_TMR_W-1:0] PKG_LAST_2K = PKG_CYCLES_2K[`MCFE_TMR_W-1:0] - 1'b1;
  localparam [`MCFE_TMR_W-1:0] HALF_LAST = HALF_BIT_CYCLES[`MCFE_TMR_W-1:0] - 1'b1;
  localparam [`MCFE_TMR_W-1:0] GAP_LAST = GAP_CYCLES[`MCFE_TMR_W-1:0] - 1'b1;

  reg [31:0] ctrl;
  reg [31:0] meas_data;
  reg [31:0] info_data;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] st;
  reg [`MCFE_TMR_W-1:0] pkg_tmr;
  reg [`MCFE_TMR_W-1:0] tmr;
  reg half;
  reg [3:0] bit_idx;
  reg [1:0] frame_idx;
  reg [12:0] shifter;
  reg [31:0] pkg_data;
  reg pkg_is_mfg;
  reg [7:0] manuf_left;
  reg [4:0] pkg_counter;
  reg load_pending;
  reg [7:0] cur_byte;
  reg [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode

  wire [2:0] protocol = ctrl[`MCFE_CTRL_PSEL_HI:`MCFE_CTRL_PSEL_LO];
  wire enabled = (protocol == `MCFE_PSEL_MANCH_A) | (protocol == `MCFE_PSEL_MANCH_B);
  wire info_bit = ctrl[`MCFE_CTRL_INFO];
  wire [`MCFE_TMR_W-1:0] pkg_last = ctrl[`MCFE_CTRL_RATE] ? PKG_LAST_2K : PKG_LAST_1K;
  // Compare with >= so a switch to the faster rate never lets the timer run past its wrap point
  wire pkg_tick = (pkg_tmr >= pkg_last);

  ////////////////////////////////////////////////////////////////////////////
  // Package and frame assembly

  wire start_pkg = pkg_tick & st[0] & enabled & supply_ok & ~load_pending;
  wire start_mfg = (manuf_left != 8'h00);
  wire [7:0] init_info = {info_data[23:20], info_bit, info_data[18:16]};
  wire [7:0] mfg_f2 = (pkg_counter == 5'h00) ? init_info : info_data[23:16];
  wire [31:0] mfg_pkg = {`MCFE_MFG_TAG, ctrl[`MCFE_CTRL_OK], pkg_counter, mfg_f2, info_data[15:0]};
  wire [31:0] meas_pkg = {info_bit, meas_data[30:0]};
  wire [31:0] new_pkg = start_mfg ? mfg_pkg : meas_pkg;
  wire tmr_end_half = st[1] & (tmr == HALF_LAST);
  wire gap_end = st[2] & (tmr == GAP_LAST);
  wire last_bit = (bit_idx == `MCFE_LAST_BIT);
  wire last_frame = (frame_idx == `MCFE_LAST_FRAME);
  wire next_frame = gap_end & ~last_frame;
  wire frame_start = start_pkg | next_frame;
  wire [1:0] next_frame_idx = start_pkg ? 2'h0 : frame_idx + 2'h1;
  wire [31:0] next_data = start_pkg ? new_pkg : pkg_data;
  wire next_mfg = start_pkg ? start_mfg : pkg_is_mfg;
  // Label is the inverted frame index: 11, 10, 01, 00
  wire [11:0] frame_body = {`MCFE_START_BITS, ~next_frame_idx, cur_byte};
  // Odd total ones for manufacturing, even for measurement
  wire parity = next_mfg ? ~^frame_body : ^frame_body;
  wire [12:0] frame_word = {frame_body, parity};
  wire abort = ~supply_ok & ~st[0];

  always @*
  begin
    case (next_frame_idx)
      2'h0: cur_byte = next_data[31:24];
      2'h1: cur_byte = next_data[23:16];
      2'h2: cur_byte = next_data[15:8];
      default: cur_byte = next_data[7:0];
    endcase
  end

  // Strobes to the line coder
  wire bit_load = frame_start | (tmr_end_half & half & ~last_bit);
  wire bit_value = frame_start ? frame_word[12] : shifter[11];
  wire mid_bit = tmr_end_half & ~half;
  wire go_idle = abort | (tmr_end_half & half & last_bit);

  mcfe_manchester_bit u_line
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_load(bit_load),
    .bit_value(bit_value),
    .mid_bit(mid_bit),
    .go_idle(go_idle),
    .current_high(tx_current_high)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Package timer, free running so the device owns the repetition rate

  always @(posedge aclk)
  begin
    if (!aresetn)
      pkg_tmr <= {`MCFE_TMR_W{1'b0}};
    else if (pkg_tick)
      pkg_tmr <= {`MCFE_TMR_W{1'b0}};
    else
      pkg_tmr <= pkg_tmr + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framer state machine

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= ST_IDLE;
      tmr <= {`MCFE_TMR_W{1'b0}};
      half <= 1'b0;
      bit_idx <= 4'h0;
      frame_idx <= 2'h0;
      shifter <= 13'h0000;
      pkg_data <= 32'h00000000;
      pkg_is_mfg <= 1'b0;
      tx_active <= 1'b0;
    end
    else if (abort)
    begin
      st <= ST_IDLE;
      tx_active <= 1'b0;
    end
    else if (frame_start)
    begin
      st <= ST_BIT;
      tmr <= {`MCFE_TMR_W{1'b0}};
      half <= 1'b0;
      bit_idx <= 4'h0;
      frame_idx <= next_frame_idx;
      shifter <= frame_word;
      pkg_data <= next_data;
      pkg_is_mfg <= next_mfg;
      tx_active <= 1'b1;
    end
    else
    begin
      case (st)
        ST_BIT:
        begin
          if (tmr_end_half)
          begin
            tmr <= {`MCFE_TMR_W{1'b0}};
            half <= ~half;
            if (half & last_bit)
              st <= ST_GAP;
            else if (half)
            begin
              bit_idx <= bit_idx + 4'h1;
              shifter <= {shifter[11:0], 1'b0};
            end
          end
          else
            tmr <= tmr + 1'b1;
        end
        ST_GAP:
        begin
          if (gap_end)
          begin
            // Last frame done: wait at low current for the next package tick
            st <= ST_IDLE;
            tx_active <= 1'b0;
            tmr <= {`MCFE_TMR_W{1'b0}};
          end
          else
            tmr <= tmr + 1'b1;
        end
        ST_IDLE:
          tmr <= {`MCFE_TMR_W{1'b0}};
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup manufacturing sequence; the count is taken once after reset
  // release, so a supply dip never restarts it

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_pending <= 1'b1;
      manuf_left <= 8'h00;
      pkg_counter <= 5'h00;
    end
    else if (load_pending)
    begin
      load_pending <= 1'b0;
      manuf_left <= ctrl[`MCFE_CTRL_CNT_HI:`MCFE_CTRL_CNT_LO];
    end
    else if (~supply_ok)
      manuf_left <= 8'h00;
    else if (start_pkg & start_mfg)
    begin
      manuf_left <= manuf_left - 8'h01;
      pkg_counter <= pkg_counter + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge = old_val;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [7:0] wr_ofs = {aw_addr[7:2], 2'b00};
  wire [7:0] rd_ofs = {s_axi_araddr[7:2], 2'b00};
  wire wr_hit = (wr_ofs == `MCFE_OFS_CTRL) | (wr_ofs == `MCFE_OFS_MEAS) | (wr_ofs == `MCFE_OFS_INFO);
  wire wr_hit_rd = (rd_ofs == `MCFE_OFS_CTRL) | (rd_ofs == `MCFE_OFS_MEAS) | (rd_ofs == `MCFE_OFS_INFO);
  wire rd_hit = wr_hit_rd | (rd_ofs == `MCFE_OFS_STATUS);
  wire [31:0] status = {8'h00, manuf_left, 3'h0, pkg_counter, 2'h0, frame_idx, 1'b0, start_mfg, tx_active, ~st[0]};

  always @*
  begin
    case (rd_ofs)
      `MCFE_OFS_CTRL: rd_mux = ctrl;
      `MCFE_OFS_MEAS: rd_mux = meas_data;
      `MCFE_OFS_INFO: rd_mux = info_data;
      `MCFE_OFS_STATUS: rd_mux = status;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCFE_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      ctrl <= `MCFE_CTRL_RST;
      meas_data <= 32'h00000000;
      info_data <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `MCFE_RESP_OKAY : `MCFE_RESP_SLVERR;
        if (wr_ofs == `MCFE_OFS_CTRL)
          ctrl <= merge(ctrl, w_data, w_strb) & `MCFE_CTRL_MASK;
        if (wr_ofs == `MCFE_OFS_MEAS)
          meas_data <= merge(meas_data, w_data, w_strb);
        if (wr_ofs == `MCFE_OFS_INFO)
          info_data <= merge(info_data, w_data, w_strb);
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MCFE_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `MCFE_RESP_OKAY : `MCFE_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // mcfe_frame_encoder

// [core/mcfe_map.vh]
// Constants for the Manchester current frame encoder: register map,
// field positions, reset values, protocol codes and timing figures.
// Assumes a 200 MHz core clock; included by its bare name.
`ifndef MCFE_MAP_VH
`define MCFE_MAP_VH

// Register byte offsets (one aligned 32-bit word each)
`define MCFE_OFS_CTRL 8'h00
`define MCFE_OFS_MEAS 8'h04
`define MCFE_OFS_INFO 8'h08
`define MCFE_OFS_STATUS 8'h0c

// Control register fields
`define MCFE_CTRL_RATE 0
`define MCFE_CTRL_PSEL_LO 4
`define MCFE_CTRL_PSEL_HI 6
`define MCFE_CTRL_INFO 8
`define MCFE_CTRL_OK 9
`define MCFE_CTRL_CNT_LO 16
`define MCFE_CTRL_CNT_HI 23
`define MCFE_CTRL_MASK 32'h00ff0371
`define MCFE_CTRL_RST 32'h00040010

// Protocol selector codes that enable this encoder
`define MCFE_PSEL_MANCH_A 3'h1
`define MCFE_PSEL_MANCH_B 3'h2

// Frame layout
`define MCFE_LAST_BIT 4'hc
`define MCFE_LAST_FRAME 2'h3
`define MCFE_START_BITS 2'h0
`define MCFE_MFG_TAG 2'h1
`define MCFE_INIT_INFO_POS 3

// AXI responses
`define MCFE_RESP_OKAY 2'h0
`define MCFE_RESP_SLVERR 2'h2

// Timing
`define MCFE_CLK_PERIOD_PS 5000
`define MCFE_PS_PER_NS 1000
`define MCFE_PS_PER_US 1000000
`define MCFE_PKG_TIME_1K_US 1000
`define MCFE_PKG_TIME_2K_US 500
`define MCFE_HALF_BIT_NS 4000
`define MCFE_FRAME_GAP_NS 10000
`define MCFE_TMR_W 18

`endif

// [core/mcfe_manchester_bit.v]
// Manchester line level generator for one current-modulated output.
// Assumes the framer gives one-cycle strobes at bit start, mid-bit and idle.
`timescale 1ns/1ps

module mcfe_manchester_bit
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Strobes from the framer
  input wire bit_load,
  input wire bit_value,
  input wire mid_bit,
  input wire go_idle,
  // Line level, 1 = high current
  output reg current_high
);

  ////////////////////////////////////////////////////////////////////////////
  // A one starts high and falls at mid-bit, a zero starts low and rises,
  // so every bit has its mid edge regardless of the neighbouring bits
  always @(posedge aclk)
  begin
    if (!aresetn)
      current_high <= 1'b0;
    else if (go_idle)
      current_high <= 1'b0;
    else if (bit_load)
      current_high <= bit_value;
    else if (mid_bit)
      current_high <= ~current_high;
  end

endmodule // mcfe_manchester_bit

// [dv/mcfe_asserts.sv]
// Checker for the frame encoder ports: bus handshakes and line coding.
// Assumes the bench runs HALF_BIT_CYCLES at 4; the start-bit shape is written for it.
`timescale 1ns/1ps

module mcfe_checker
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Link
  input wire supply_ok,
  input wire tx_current_high,
  input wire tx_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_idle_line_low: assert property (!tx_active |-> !tx_current_high)
    else $error("line high while idle");
  a_dip_drops_line: assert property (!supply_ok |=> !tx_current_high)
    else $error("line not low after supply dip");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("no write response two cycles after both taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read data one cycle after address");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel ready while data pending");
  // Two zero start bits: low half, rising edge, low half, rising edge; a supply dip may cut the frame
  a_start_bits: assert property (disable iff (!aresetn || !supply_ok)
    $rose(tx_active) |-> !tx_current_high[*4] ##1 tx_current_high[*4]
    ##1 !tx_current_high[*4] ##1 tx_current_high)
    else $error("frame does not open with two zero bits");
  // A mid-bit edge in every bit caps any high run at two halves
  a_high_run: assert property (tx_active && tx_current_high |-> ##[1:8] !tx_current_high)
    else $error("line high too long for manchester coding");
endmodule // mcfe_checker

bind mcfe_frame_encoder mcfe_checker u_chk
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .supply_ok(supply_ok), .tx_current_high(tx_current_high), .tx_active(tx_active)
);

// [dv/mcfe_ecu_model.sv]
// Receiver model: decodes manchester frames from the current line.
// Assumes frames start when tx_active rises and keep fixed bit and gap lengths.
`timescale 1ns/1ps

module mcfe_ecu_model #(parameter HALF = 4, parameter GAP = 8)
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Line from the encoder
  input wire tx_current_high,
  input wire tx_active,
  // Decoded frames
  output logic [12:0] rx_word,
  output logic rx_stb,
  output logic rx_err
);
  int cnt;
  int pos;
  logic first;
  assign pos = cnt % (26 * HALF + GAP);
  ////////////////////
  // Sample mid-half so an edge slip of a cycle still decodes
  always @(posedge aclk)
  begin
    rx_stb <= 1'b0;
    if (!aresetn)
      rx_err <= 1'b0;
    if (!aresetn || !tx_active)
      cnt <= 0;
    else
    begin
      cnt <= cnt + 1;
      if (pos < 26 * HALF && pos % (2 * HALF) == HALF / 2)
        first <= tx_current_high;
      if (pos < 26 * HALF && pos % (2 * HALF) == HALF + HALF / 2)
      begin
        rx_word <= {rx_word[11:0], first};
        if (first == tx_current_high)
          rx_err <= 1'b1;
      end
      if (pos == 26 * HALF - 1)
        rx_stb <= 1'b1;
    end
  end
endmodule // mcfe_ecu_model

// [dv/testbench.sv]
// Bench for the frame encoder: registers, startup packages, rates, modes, dip.
// Assumes the receiver model decodes the line; short timing parameters keep the run brief.
`timescale 1ns/1ps

module testbench;
  localparam int LIMIT = 90000;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic awvalid = 0;
  logic [31:0] wdata = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic [7:0] araddr = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic supply_ok = 1;
  wire awready, wready, bvalid, arready, rvalid, tx_current_high, tx_active, rx_stb, rx_err;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] rx_word;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int last_rise = 0;
  int period = 0;
  logic act_q = 0;
  logic saw;
  logic [1:0] r;
  logic [31:0] d, ctl, meas, info;

  always #2.5 aclk = ~aclk;

  mcfe_frame_encoder #(.PKG_CYCLES_1K(3000), .PKG_CYCLES_2K(2500), .HALF_BIT_CYCLES(4), .GAP_CYCLES(8)) DUT
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_ok(supply_ok),
    .tx_current_high(tx_current_high), .tx_active(tx_active)
  );

  mcfe_ecu_model ECU (.aclk(aclk), .aresetn(aresetn), .tx_current_high(tx_current_high),
    .tx_active(tx_active), .rx_word(rx_word), .rx_stb(rx_stb), .rx_err(rx_err));

  ////////////////////
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    act_q <= tx_active;
    if (tx_active && !act_q)
    begin
      period <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [12:0] frm(input logic [1:0] lb, input logic [7:0] by, input logic odd);
    return {2'b00, lb, by, ^{lb, by} ^ odd};
  endfunction

  task automatic pkg(input logic mfg, input logic [4:0] k);
    logic [7:0] by [4];
    int t;
    by[0] = mfg ? {2'b01, ctl[9], k} : {ctl[8], meas[30:24]};
    // The first manufacturing package carries the info bit in bit 3 of frame two
    by[1] = mfg ? ((k == 5'h00) ? {info[23:20], ctl[8], info[18:16]} : info[23:16]) : meas[23:16];
    by[2] = mfg ? info[15:8] : meas[15:8];
    by[3] = mfg ? info[7:0] : meas[7:0];
    for (int f = 0; f < 4; f++)
    begin
      t = 0;
      do
      begin
        @(posedge aclk);
        t++;
      end
      while (!rx_stb && t < 4000);
      chk("frame", {19'h0, rx_word}, {19'h0, frm(2'h3 - f[1:0], by[f], mfg)});
    end
  endtask

  ////////////////////
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r);
    chk("ctrl reset", d, 32'h00040010);
    rd(8'h10, d, r);
    chk("unmapped rresp", {30'h0, r}, 32'h2);
    wr(8'h0c, 32'h1, 2'h2);
    meas = 32'h7e815aa5;
    info = 32'h00c33c0f;
    ctl = 32'h00040310;
    wr(8'h04, meas, 2'h0);
    wr(8'h08, info, 2'h0);
    wr(8'h00, ctl, 2'h0);
    for (int k = 0; k < 4; k++)
      pkg(1'b1, k[4:0]);
    pkg(1'b0, 5'h0);
    chk("1k period", period, 32'd3000);
    chk("coding", {31'h0, rx_err}, 32'h0);
    ctl[0] = 1'b1;
    wr(8'h00, ctl, 2'h0);
    pkg(1'b0, 5'h0);
    pkg(1'b0, 5'h0);
    chk("2k period", period, 32'd2500);
    $display("test packages done");
    for (int c = 0; c < 8; c++)
    begin
      ctl[6:4] = c[2:0];
      wr(8'h00, ctl, 2'h0);
      while (tx_active)
        @(posedge aclk);
      saw = 1'b0;
      repeat (2600)
      begin
        @(posedge aclk);
        saw = saw | tx_active;
      end
      chk("enable", {31'h0, saw}, {31'h0, c == 1 || c == 2});
    end
    $display("test modes done");
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h0c, d, r);
    chk("status after reset", d, 32'h00040004);
    chk("status rresp", {30'h0, r}, 32'h0);
    ctl = 32'h00040010;
    wr(8'h04, meas, 2'h0);
    while (!tx_active)
      @(posedge aclk);
    supply_ok <= 1'b0;
    repeat (10) @(posedge aclk);
    supply_ok <= 1'b1;
    pkg(1'b0, 5'h0);
    $display("test supply dip done");
    stop_test();
  end
endmodule // testbench
